// ==== hdl/tmnt_test_mode.sv ====
// Summary of operation
// RULE1 - mode is chosen from bale and irq3..irq7 latched during reset.
// RULE2 - bale low and irq7 low at reset selects nand tree mode.
// RULE3 - pattern 1,0,0,1,1 sets chain select, clears shift enable.
// RULE4 - pattern 1,0,1,1,1 sets chain select, shift enable, bus off.
// RULE5 - all other patterns give normal operation after reset.
// RULE6 - nand mode floats all pins except tc and rstdrv.
// RULE7 - first chain input is the pin after the supply pair.
// RULE8 - tc shows intermediate result, rstdrv the final result.
// RULE9 - bale, pci reset and irq7 never enter the chain.
// RULE10 - chain follows package pin order, skipping supplies and bale.
// RULE11 - each stage nands its pin with the previous stage.
`timescale 1ns/1ps
module tmnt_test_mode
	import tmnt_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 reset,
	input  wire logic                 bale_in,
	input  wire logic [STRAP_W-1:0]   irq_strap_in,
	input  wire logic [CHAIN_LEN-1:0] chain_pins_in,
	input  wire logic                 func_tc,
	input  wire logic                 func_tc_oe,
	input  wire logic                 func_rstdrv,
	output logic                      nand_mode,
	output logic                      pins_float,
	output logic                      shift_chain_select,
	output logic                      shift_chain_shift_enable,
	output logic                      internal_bus_off,
	output logic                      tc_out,
	output logic                      tc_oe,
	output logic                      rstdrv_out,
	output logic                      rstdrv_oe
);
	// -------------------------------------------------------------------------
	// types
	// -------------------------------------------------------------------------
	// flags that a test mode shows on its outputs
	typedef struct packed {
		logic nand_mode;
		logic pins_float;
		logic chain_sel;
		logic chain_shift;
		logic bus_off;
	} tmnt_flags_t;

	// the two pins that stay alive in nand mode
	typedef struct packed {
		logic tc;
		logic tc_oe;
		logic rstdrv;
		logic rstdrv_oe;
	} tmnt_pins_t;

	// capture: straps sampled or just released; run: mode frozen until next reset
	typedef enum logic {
		TMNT_PH_CAPTURE,
		TMNT_PH_RUN
	} tmnt_phase_t;

	typedef struct packed {
		logic               bale_strap;
		logic [STRAP_W-1:0] irq_strap;
		tmnt_phase_t        phase;
		tmnt_mode_t         mode;
		tmnt_flags_t        flags;
		tmnt_pins_t         pins;
	} tmnt_state_t;

	tmnt_state_t state_reg;
	tmnt_state_t state_next;

	// -------------------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------------------
	// one table for reset and run, so the two paths cannot drift apart;
	// the scan modes only raise the flags, the chains themselves live elsewhere
	function automatic tmnt_flags_t mode_flags(input tmnt_mode_t m);
		tmnt_flags_t f;
		f = '0;
		case (m)
			TMNT_NAND: begin
				f.nand_mode   = 1'b1; // RULE2
				f.pins_float  = 1'b1; // RULE6
				f.chain_sel   = 1'b0;
				f.chain_shift = 1'b0;
				f.bus_off     = 1'b0;
			end
			TMNT_SCAN_HOLD: begin
				f.nand_mode   = 1'b0;
				f.pins_float  = 1'b0;
				f.chain_sel   = 1'b1; // RULE3
				f.chain_shift = 1'b0; // RULE3
				f.bus_off     = 1'b0;
			end
			TMNT_SCAN_SHIFT: begin
				f.nand_mode   = 1'b0;
				f.pins_float  = 1'b0;
				f.chain_sel   = 1'b1; // RULE4
				f.chain_shift = 1'b1; // RULE4
				f.bus_off     = 1'b1; // RULE4
			end
			default: begin
				// reserved patterns land here too; nothing records that one was seen
				f.nand_mode   = 1'b0; // RULE5
				f.pins_float  = 1'b0; // RULE5
				f.chain_sel   = 1'b0; // RULE5
				f.chain_shift = 1'b0; // RULE5
				f.bus_off     = 1'b0; // RULE5
			end
		endcase
		return f;
	endfunction : mode_flags

	// in nand mode the tester reads the chain on tc and rstdrv; otherwise the
	// functional logic keeps both pins
	function automatic tmnt_pins_t pin_drive(
		input logic nand_on,
		input logic tap,
		input logic fin,
		input logic f_tc,
		input logic f_tc_oe,
		input logic f_rstdrv
	);
		tmnt_pins_t p;
		p = '0;
		if (nand_on) begin
			p.tc     = tap; // RULE8
			p.tc_oe  = 1'b1; // RULE8
			p.rstdrv = fin; // RULE8
		end else begin
			p.tc     = f_tc;
			p.tc_oe  = f_tc_oe;
			p.rstdrv = f_rstdrv;
		end
		// rstdrv never floats: it resets the slots normally and is the last
		// chain stage in test
		p.rstdrv_oe = 1'b1; // RULE6
		return p;
	endfunction : pin_drive

	// -------------------------------------------------------------------------
	// nand chain
	// -------------------------------------------------------------------------
	tmnt_chain_if chain_bus ();

	// bale and irq7 are not wired into chain_pins_in at all; they hold the mode
	assign chain_bus.chain_in = chain_pins_in; // RULE9

	tmnt_nand_chain u_chain (
		.bus (chain_bus)
	);

	// -------------------------------------------------------------------------
	// next state
	// -------------------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		if (reset) begin
			// straps follow the pins for as long as reset is held; the last
			// level before release is the one that counts
			state_next.bale_strap = bale_in; // RULE1
			state_next.irq_strap  = irq_strap_in; // RULE1
			state_next.phase      = TMNT_PH_CAPTURE;
			state_next.mode       = TMNT_NORMAL;
			state_next.flags      = mode_flags(TMNT_NORMAL);
			state_next.pins       = pin_drive(
				1'b0,
				chain_bus.tap_out,
				chain_bus.final_out,
				func_tc,
				func_tc_oe,
				func_rstdrv
			);
		end else begin
			case (state_reg.phase)
				TMNT_PH_CAPTURE: begin
					// decode once on the first edge out of reset; the strap pins
					// are free for normal traffic from then on
					state_next.mode  = tmnt_decode(state_reg.bale_strap,
					                               state_reg.irq_strap); // RULE1 RULE5
					state_next.phase = TMNT_PH_RUN;
				end
				TMNT_PH_RUN: begin
					state_next.mode  = state_reg.mode;
					state_next.phase = TMNT_PH_RUN;
				end
				default: begin
					state_next.mode  = TMNT_NORMAL;
					state_next.phase = TMNT_PH_RUN;
				end
			endcase
			state_next.flags = mode_flags(state_next.mode);
			state_next.pins  = pin_drive(
				state_next.flags.nand_mode,
				chain_bus.tap_out,
				chain_bus.final_out,
				func_tc,
				func_tc_oe,
				func_rstdrv
			);
		end
	end

	// -------------------------------------------------------------------------
	// registers
	// -------------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		state_reg <= state_next;
	end

	// -------------------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------------------
	// every pin is a plain register bit, so nothing combinational reaches a pad
	assign nand_mode                = state_reg.flags.nand_mode;
	assign pins_float               = state_reg.flags.pins_float;
	assign shift_chain_select       = state_reg.flags.chain_sel;
	assign shift_chain_shift_enable = state_reg.flags.chain_shift;
	assign internal_bus_off         = state_reg.flags.bus_off;
	assign tc_out                   = state_reg.pins.tc;
	assign tc_oe                    = state_reg.pins.tc_oe;
	assign rstdrv_out               = state_reg.pins.rstdrv;
	assign rstdrv_oe                = state_reg.pins.rstdrv_oe; // RULE6
endmodule : tmnt_test_mode

// ==== hdl/tmnt_pkg.sv ====
package tmnt_pkg;
	// -------------------------------------------------------------------------
	// chain geometry
	// -------------------------------------------------------------------------
	// chain_in bit 0 is the first chained pin, the one next to the supply pair
	localparam int unsigned CHAIN_LEN   = 64;
	// index of the last stage that feeds the intermediate observation pin
	localparam int unsigned CHAIN_TAP   = 52;

	// -------------------------------------------------------------------------
	// strap layout: {irq7, irq6, irq5, irq4, irq3}
	// -------------------------------------------------------------------------
	localparam int unsigned STRAP_W      = 5;
	localparam int unsigned STRAP_IRQ7   = 4;
	localparam logic [4:0]  STRAP_SCAN_A = 5'h19;
	localparam logic [4:0]  STRAP_SCAN_B = 5'h1d;
	localparam logic [4:0]  STRAP_RESET  = 5'h1f;

	typedef enum logic [1:0] {
		TMNT_NORMAL,
		TMNT_NAND,
		TMNT_SCAN_HOLD,
		TMNT_SCAN_SHIFT
	} tmnt_mode_t;

	function automatic tmnt_mode_t tmnt_decode(input logic bale, input logic [4:0] irq);
		tmnt_mode_t m;
		m = TMNT_NORMAL;
		if (bale) begin
			m = TMNT_NORMAL;
		end else if (!irq[STRAP_IRQ7]) begin
			m = TMNT_NAND;
		end else if (irq == STRAP_SCAN_A) begin
			m = TMNT_SCAN_HOLD;
		end else if (irq == STRAP_SCAN_B) begin
			m = TMNT_SCAN_SHIFT;
		end
		return m;
	endfunction : tmnt_decode
endpackage : tmnt_pkg

// ==== hdl/tmnt_chain_if.sv ====
`timescale 1ns/1ps
interface tmnt_chain_if;
	import tmnt_pkg::*;
	logic [CHAIN_LEN-1:0] chain_in;
	logic                 tap_out;
	logic                 final_out;
	modport ctrl  (output chain_in, input tap_out, final_out);
	modport chain (input chain_in, output tap_out, final_out);
endinterface : tmnt_chain_if

// ==== hdl/tmnt_nand_chain.sv ====
`timescale 1ns/1ps
module tmnt_nand_chain
	import tmnt_pkg::*;
(
	tmnt_chain_if.chain bus
);
	logic [CHAIN_LEN-1:0] stage;

	// first stage nands with a constant one, so it is a plain inverter
	always_comb begin
		stage[0] = ~(bus.chain_in[0] & 1'b1); // RULE7 RULE11
		for (int i = 1; i < CHAIN_LEN; i++) begin
			stage[i] = ~(bus.chain_in[i] & stage[i-1]); // RULE10 RULE11
		end
	end

	assign bus.tap_out   = stage[CHAIN_TAP];
	assign bus.final_out = stage[CHAIN_LEN-1];
endmodule : tmnt_nand_chain

// ==== test/tmnt_checker_assertions.sv ====
`timescale 1ns/1ps
module tmnt_checker
	import tmnt_pkg::*;
(
	input logic                 core_clk,
	input logic                 reset,
	input logic                 bale_in,
	input logic [STRAP_W-1:0]   irq_strap_in,
	input logic [CHAIN_LEN-1:0] chain_pins_in,
	input logic                 nand_mode,
	input logic                 pins_float,
	input logic                 shift_chain_select,
	input logic                 shift_chain_shift_enable,
	input logic                 internal_bus_off,
	input logic                 tc_out,
	input logic                 tc_oe,
	input logic                 rstdrv_out,
	input logic                 rstdrv_oe
);
	logic               b_reg;
	logic [STRAP_W-1:0] s_reg;
	always_ff @(posedge core_clk) if (reset) begin
		b_reg <= bale_in;
		s_reg <= irq_strap_in;
	end
	function automatic logic stg(input logic [CHAIN_LEN-1:0] v, input int n);
		logic s;
		s = ~v[0];
		for (int i = 1; i <= n; i++) s = ~(v[i] & s);
		return s;
	endfunction : stg
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	a_nand_sel: assert property (!$past(reset) |-> nand_mode == (!b_reg && !s_reg[STRAP_IRQ7]))
		else $error("nand select wrong");
	a_float_nand: assert property (pins_float == nand_mode)
		else $error("float wrong");
	a_scan_sel: assert property (!$past(reset) |-> shift_chain_select ==
		(!b_reg && (s_reg == STRAP_SCAN_A || s_reg == STRAP_SCAN_B))) else $error("select wrong");
	a_scan_shift: assert property (!$past(reset) |-> shift_chain_shift_enable ==
		(!b_reg && s_reg == STRAP_SCAN_B)) else $error("shift wrong");
	a_bus_off: assert property (internal_bus_off == shift_chain_shift_enable)
		else $error("bus off wrong");
	a_pins_drive: assert property (rstdrv_oe && (!nand_mode || tc_oe))
		else $error("drive wrong");
	a_tap_out: assert property (nand_mode && $past(nand_mode) |->
		tc_out == stg($past(chain_pins_in), CHAIN_TAP)) else $error("tap wrong");
	a_final_out: assert property (nand_mode && $past(nand_mode) |->
		rstdrv_out == stg($past(chain_pins_in), CHAIN_LEN - 1)) else $error("final wrong");
endmodule : tmnt_checker
bind tmnt_test_mode tmnt_checker tmnt_checker_inst (.core_clk, .reset, .bale_in, .irq_strap_in,
	.chain_pins_in, .nand_mode, .pins_float, .shift_chain_select, .shift_chain_shift_enable,
	.internal_bus_off, .tc_out, .tc_oe, .rstdrv_out, .rstdrv_oe);

// ==== test/tmnt_tester.sv ====
`timescale 1ns/1ps
module tmnt_tester
	import tmnt_pkg::*;
(
	input  logic                 core_clk,
	output logic                 bale_in = 1'h1,
	output logic [STRAP_W-1:0]   irq_strap_in = '1,
	output logic [CHAIN_LEN-1:0] chain_pins_in = '1
);
	// straps mean something only while reset is held
	task automatic straps(input logic b, input logic [STRAP_W-1:0] s);
		@(negedge core_clk);
		bale_in = b;
		irq_strap_in = s;
	endtask : straps
	task automatic pins(input logic [CHAIN_LEN-1:0] v);
		@(negedge core_clk);
		chain_pins_in = v;
	endtask : pins
endmodule : tmnt_tester

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	import tmnt_pkg::*;
	logic core_clk = 1'h0, reset = 1'h1, func_tc = 1'h0, func_tc_oe = 1'h0, func_rstdrv = 1'h0;
	logic bale_in, nand_mode, pins_float, sel, shen, boff, tc_out, tc_oe, rstdrv_out, rstdrv_oe;
	logic [STRAP_W-1:0]   irq_strap_in;
	logic [CHAIN_LEN-1:0] chain_pins_in;
	int err_count = 0;
	int compares = 0;
	always #2.5 core_clk = ~core_clk;
	tmnt_tester tmnt_tester_inst (.core_clk, .bale_in, .irq_strap_in, .chain_pins_in);
	tmnt_test_mode tmnt_test_mode_inst (.core_clk, .reset, .bale_in, .irq_strap_in,
		.chain_pins_in, .func_tc, .func_tc_oe, .func_rstdrv, .nand_mode, .pins_float,
		.shift_chain_select(sel), .shift_chain_shift_enable(shen), .internal_bus_off(boff),
		.tc_out, .tc_oe, .rstdrv_out, .rstdrv_oe);
	task automatic chk(input logic [5:0] got, input logic [5:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic boot(input logic b, input logic [4:0] s);
		tmnt_tester_inst.straps(b, s);
		reset = 1'h1;
		repeat (5) @(negedge core_clk);
		reset = 1'h0;
		repeat (2) @(negedge core_clk);
		chk({nand_mode, pins_float, sel, shen, boff, rstdrv_oe}, {b, s} == 6'h19 ? 6'h09 :
			{b, s} == 6'h1d ? 6'h0f : (!b && !s[4]) ? 6'h31 : 6'h01);
	endtask : boot
	task automatic pin_chk(input logic [CHAIN_LEN-1:0] v, input logic [2:0] exp);
		tmnt_tester_inst.pins(v);
		@(negedge core_clk);
		chk({3'h0, tc_oe, tc_out, rstdrv_out}, {3'h0, exp});
	endtask : pin_chk
	task automatic t_nand;
		boot(1'h0, 5'h00);
		boot(1'h0, 5'h0f);
		pin_chk('1, 3'h5);
		pin_chk(~64'h1, 3'h6);
		pin_chk(~(64'h1 << 62), 3'h4);
	endtask : t_nand
	task automatic t_scan;
		boot(1'h0, 5'h19);
		boot(1'h0, 5'h1d);
	endtask : t_scan
	task automatic t_normal;
		boot(1'h0, 5'h12);
		boot(1'h0, 5'h1f);
		boot(1'h1, 5'h00);
		func_tc = 1'h1;
		func_tc_oe = 1'h1;
		func_rstdrv = 1'h1;
		@(negedge core_clk);
		@(negedge core_clk);
		chk({3'h0, tc_oe, tc_out, rstdrv_out}, 6'h07);
	endtask : t_normal
	task automatic wrap_up;
		if (err_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	initial begin
		t_nand();
		t_scan();
		t_normal();
		wrap_up();
	end
endmodule : tb_top
